// ===== hw/fmv_transform.sv
// matrix by vector transform execution unit
`timescale 1ns/1ps
`include "fmv_map.svh"

module fmv_transform
    import fmv_pkg::*;
(
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic         issueValid,
    input  wire logic [15:0]  instrWord,
    input  wire logic         precisionSelect,
    input  wire logic [3:0]   enableVoui,
    input  wire logic [3:0]   flagIn,
    input  wire logic [511:0] backBankRegs,
    input  wire logic [511:0] frontBankRegs,
    output logic              busy_q,
    output logic              done_q,
    output logic              writeEn_q,
    output logic              trap_q,
    output logic              undefOp_q,
    output logic      [3:0]   vecBase_q,
    output logic      [127:0] result_q,
    output logic      [3:0]   cause_q,
    output logic      [3:0]   flag_q
);

    // ************************************************************
    // operand classification
    // ************************************************************
    function automatic fmv_class_t classOf(input logic [31:0] w);
        fmv_class_t c;
        if (w[30:23] == 8'hFF) begin
            if (w[22:0] == 23'h0) begin
                c = FMV_CL_INF;
            end else if (w[22]) begin
                c = FMV_CL_QNAN;
            end else begin
                c = FMV_CL_SNAN;
            end
        end else if (w[30:23] == 8'h00) begin
            c = FMV_CL_ZERO;
        end else begin
            c = FMV_CL_NORM;
        end
        return c;
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    fmv_state_t       state_q;
    fmv_state_t       state_d;
    logic [1:0]       row_q;
    logic [1:0]       row_d;
    logic [31:0]      mat_q [16];
    logic [31:0]      mat_d [16];
    logic [31:0]      vec_q [4];
    logic [31:0]      vec_d [4];
    logic [3:0]       en_q;
    logic [3:0]       en_d;
    logic             busy_d;
    logic             done_d;
    logic             writeEn_d;
    logic             trap_d;
    logic             undefOp_d;
    logic [3:0]       vecBase_d;
    logic [127:0]     result_d;
    logic [3:0]       cause_d;
    logic [3:0]       flag_d;

    // ************************************************************
    // current row operands and arithmetic
    // ************************************************************
    logic [127:0]     rowBus;
    logic [127:0]     vecBus;
    logic [31:0]      dot;
    logic             dotOvf;
    logic             dotUnf;
    logic             dotInex;
    logic             opMatch;

    assign opMatch = (instrWord & `FMV_OP_MASK) == `FMV_OP_MATCH;

    always_comb begin
        rowBus = '0;
        vecBus = '0;
        for (int j = 0; j < 4; j++) begin
            rowBus[32*j +: 32] = mat_q[{2'(j), row_q}];
            vecBus[32*j +: 32] = vec_q[j];
        end
    end

    fmv_inner_product u_dot (
        .rowIn   (rowBus),
        .vecIn   (vecBus),
        .dotOut  (dot),
        .ovfOut  (dotOvf),
        .unfOut  (dotUnf),
        .inexOut (dotInex)
    );

    // ************************************************************
    // special operand handling for the current row
    // ************************************************************
    logic [31:0]      rowRes;
    logic [3:0]       rowCause;
    logic             anySnan;
    logic             anyQnan;
    logic             zeroInf;
    logic             posInf;
    logic             negInf;
    fmv_class_t       ca;
    fmv_class_t       cb;

    always_comb begin
        anySnan  = 1'b0;
        anyQnan  = 1'b0;
        zeroInf  = 1'b0;
        posInf   = 1'b0;
        negInf   = 1'b0;
        ca       = FMV_CL_ZERO;
        cb       = FMV_CL_ZERO;
        rowRes   = dot;
        rowCause = '0;
        for (int j = 0; j < 4; j++) begin
            ca = classOf(rowBus[32*j +: 32]);
            cb = classOf(vecBus[32*j +: 32]);
            anySnan = anySnan | (ca == FMV_CL_SNAN) | (cb == FMV_CL_SNAN);
            anyQnan = anyQnan | (ca == FMV_CL_QNAN) | (cb == FMV_CL_QNAN);
            zeroInf = zeroInf
                    | ((ca == FMV_CL_ZERO) && (cb == FMV_CL_INF))
                    | ((ca == FMV_CL_INF) && (cb == FMV_CL_ZERO));
            if ((ca == FMV_CL_INF || cb == FMV_CL_INF)
                && ca != FMV_CL_ZERO && cb != FMV_CL_ZERO) begin
                if (rowBus[32*j+31] ^ vecBus[32*j+31]) begin
                    negInf = 1'b1;
                end else begin
                    posInf = 1'b1;
                end
            end
        end
        if (anySnan || zeroInf) begin
            rowRes = `FMV_QNAN;
            rowCause[`FMV_BIT_V] = 1'b1;
        end else if (anyQnan) begin
            rowRes = `FMV_QNAN;
        end else if (posInf && negInf) begin
            rowRes = `FMV_QNAN;
            rowCause[`FMV_BIT_V] = 1'b1;
        end else if (posInf || negInf) begin
            rowRes = {negInf, `FMV_INF_MAG};
        end else begin
            rowCause[`FMV_BIT_O] = dotOvf;
            rowCause[`FMV_BIT_U] = dotUnf;
            rowCause[`FMV_BIT_I] = dotInex;
        end
    end

    // ************************************************************
    // sequencer next values
    // ************************************************************
    always_comb begin
        state_d   = state_q;
        row_d     = row_q;
        mat_d     = mat_q;
        vec_d     = vec_q;
        en_d      = en_q;
        busy_d    = busy_q;
        done_d    = 1'b0;
        writeEn_d = 1'b0;
        trap_d    = 1'b0;
        undefOp_d = 1'b0;
        vecBase_d = vecBase_q;
        result_d  = result_q;
        cause_d   = cause_q;
        flag_d    = flag_q;
        case (state_q)
            FMV_ST_IDLE: begin
                if (issueValid && opMatch) begin
                    if (precisionSelect) begin
                        undefOp_d = 1'b1;
                    end else begin
                        for (int k = 0; k < 16; k++) begin
                            mat_d[k] = backBankRegs[32*k +: 32];
                        end
                        vecBase_d = {instrWord[`FMV_OP_VSEL_LSB +: 2],
                                     2'b00};
                        for (int j = 0; j < 4; j++) begin
                            vec_d[j] = frontBankRegs[32*({vecBase_d[3:2],
                                       2'(j)}) +: 32];
                        end
                        // enables saved, so no trap mid-sequence
                        en_d    = enableVoui;
                        cause_d = `FMV_RST_EXC;
                        flag_d  = flagIn;
                        row_d   = 2'd0;
                        busy_d  = 1'b1;
                        state_d = FMV_ST_RUN;
                    end
                end
            end
            FMV_ST_RUN: begin
                result_d[32*row_q +: 32] = rowRes;
                cause_d = cause_q | rowCause;
                flag_d  = flag_q | rowCause;
                if (row_q == 2'(`FMV_EXEC_STATES - 1)) begin
                    state_d   = FMV_ST_IDLE;
                    busy_d    = 1'b0;
                    done_d    = 1'b1;
                    trap_d    = |en_q;
                    writeEn_d = ~|en_q;
                end else begin
                    row_d = row_q + 2'd1;
                end
            end
            default: begin
                state_d = FMV_ST_IDLE;
                busy_d  = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q   <= FMV_ST_IDLE;
            row_q     <= 2'd0;
            for (int k = 0; k < 16; k++) begin
                mat_q[k] <= `FMV_RST_WORD;
            end
            for (int j = 0; j < 4; j++) begin
                vec_q[j] <= `FMV_RST_WORD;
            end
            en_q      <= `FMV_RST_EXC;
            busy_q    <= 1'b0;
            done_q    <= 1'b0;
            writeEn_q <= 1'b0;
            trap_q    <= 1'b0;
            undefOp_q <= 1'b0;
            vecBase_q <= `FMV_RST_BASE;
            result_q  <= '0;
            cause_q   <= `FMV_RST_EXC;
            flag_q    <= `FMV_RST_EXC;
        end else begin
            state_q   <= state_d;
            row_q     <= row_d;
            mat_q     <= mat_d;
            vec_q     <= vec_d;
            en_q      <= en_d;
            busy_q    <= busy_d;
            done_q    <= done_d;
            writeEn_q <= writeEn_d;
            trap_q    <= trap_d;
            undefOp_q <= undefOp_d;
            vecBase_q <= vecBase_d;
            result_q  <= result_d;
            cause_q   <= cause_d;
            flag_q    <= flag_d;
        end
    end

endmodule

// ===== inc/fmv_map.svh
// constants of the matrix by vector transform datapath
`ifndef FMV_MAP_SVH
`define FMV_MAP_SVH

// ****************************************************************
// instruction decode
// ****************************************************************
`define FMV_OP_MASK      16'hF3FF
`define FMV_OP_MATCH     16'hF1FD
`define FMV_OP_VSEL_LSB  10
`define FMV_EXEC_STATES  4

// ****************************************************************
// exception field bit positions (enable, cause and flag alike)
// ****************************************************************
`define FMV_BIT_V        3
`define FMV_BIT_O        2
`define FMV_BIT_U        1
`define FMV_BIT_I        0

// ****************************************************************
// arithmetic widths and special words
// ****************************************************************
`define FMV_PROD_BITS    30
`define FMV_ALIGN_BITS   28
`define FMV_EXP_BIAS     11'sd127
`define FMV_EXP_MAX      11'sd255
`define FMV_QNAN         32'h7FBF_FFFF
`define FMV_INF_MAG      31'h7F80_0000

// ****************************************************************
// reset values
// ****************************************************************
`define FMV_RST_WORD     32'h0000_0000
`define FMV_RST_EXC      4'h0
`define FMV_RST_BASE     4'h0

`endif

// ===== inc/fmv_pkg.sv
// types of the matrix by vector transform datapath
package fmv_pkg;

    // ************************************************************
    // sequencer states
    // ************************************************************
    typedef enum logic [1:0] {
        FMV_ST_IDLE = 2'b01,
        FMV_ST_RUN  = 2'b10
    } fmv_state_t;

    // ************************************************************
    // operand classes
    // ************************************************************
    typedef enum logic [2:0] {
        FMV_CL_ZERO,
        FMV_CL_NORM,
        FMV_CL_INF,
        FMV_CL_QNAN,
        FMV_CL_SNAN
    } fmv_class_t;

endpackage

// ===== hw/fmv_inner_product.sv
// reduced precision four term inner product
`timescale 1ns/1ps
`include "fmv_map.svh"

module fmv_inner_product
    import fmv_pkg::*;
(
    input  wire logic [127:0] rowIn,
    input  wire logic [127:0] vecIn,
    output logic      [31:0]  dotOut,
    output logic              ovfOut,
    output logic              unfOut,
    output logic              inexOut
);

    // ************************************************************
    // products, alignment, sum, normalisation
    // ************************************************************
    logic        [47:0]                prod [4];
    logic        [`FMV_PROD_BITS-1:0]  prodTop [4];
    logic signed [10:0]                prodExp [4];
    logic                              prodNeg [4];
    logic                              prodNz  [4];
    logic signed [10:0]                maxExp;
    logic                              anyNz;
    logic        [10:0]                shAmt;
    logic        [`FMV_PROD_BITS-1:0]  shifted;
    logic        [`FMV_ALIGN_BITS:0]   aligned;
    logic signed [31:0]                acc;
    logic        [31:0]                mag;
    logic        [4:0]                 lead;
    logic        [31:0]                nrm;
    logic        [24:0]                rnd;
    logic signed [10:0]                resExp;
    logic                              lost;
    logic                              resNeg;

    always_comb begin
        maxExp  = '0;
        anyNz   = 1'b0;
        acc     = '0;
        lost    = 1'b0;
        lead    = '0;
        shAmt   = '0;
        shifted = '0;
        aligned = '0;
        ovfOut  = 1'b0;
        unfOut  = 1'b0;
        // all four products kept to 30 bits, no separate rounding
        for (int j = 0; j < 4; j++) begin
            prod[j]    = {1'b1, rowIn[32*j +: 23]} * {1'b1, vecIn[32*j +: 23]};
            prodTop[j] = prod[j][47] ? prod[j][47:18] : prod[j][46:17];
            prodExp[j] = $signed({3'b000, rowIn[32*j+23 +: 8]})
                       + $signed({3'b000, vecIn[32*j+23 +: 8]})
                       - `FMV_EXP_BIAS
                       + $signed({10'b0, prod[j][47]});
            prodNeg[j] = rowIn[32*j+31] ^ vecIn[32*j+31];
            prodNz[j]  = (|rowIn[32*j+23 +: 8]) && (|vecIn[32*j+23 +: 8]);
            lost       = lost | (prodNz[j] && (prod[j][47]
                       ? |prod[j][17:0] : |prod[j][16:0]));
        end
        for (int j = 0; j < 4; j++) begin
            if (prodNz[j] && (!anyNz || prodExp[j] > maxExp)) begin
                maxExp = prodExp[j];
                anyNz  = 1'b1;
            end
        end
        // align to the common exponent, round to 28 bits, then sum
        for (int j = 0; j < 4; j++) begin
            if (prodNz[j]) begin
                shAmt   = 11'(maxExp - prodExp[j]);
                shifted = (shAmt > 11'd29) ? '0 : prodTop[j] >> shAmt;
                lost    = lost | (shAmt > 11'd29) | (|shifted[1:0])
                        | ((shAmt <= 11'd29) && ((shifted << shAmt)
                          != prodTop[j]));
                aligned = {1'b0, shifted[29:2]}
                        + {{`FMV_ALIGN_BITS{1'b0}}, shifted[1]};
                if (prodNeg[j]) begin
                    acc = acc - $signed({3'b000, aligned});
                end else begin
                    acc = acc + $signed({3'b000, aligned});
                end
            end
        end
        resNeg = acc[31];
        mag    = resNeg ? 32'(-acc) : 32'(acc);
        for (int k = 0; k < 32; k++) begin
            if (mag[k]) begin
                lead = 5'(k);
            end
        end
        // normalise and round to single precision
        nrm     = mag << (5'd31 - lead);
        rnd     = {1'b0, nrm[31:8]} + {24'h00_0000, nrm[7]};
        lost    = lost | (|nrm[7:0]);
        resExp  = maxExp + $signed({6'b0, lead}) - 11'sd27
                + $signed({10'b0, rnd[24]});
        inexOut = lost && (mag != '0);
        if (mag == '0) begin
            dotOut = `FMV_RST_WORD;
        end else if (resExp >= `FMV_EXP_MAX) begin
            ovfOut  = 1'b1;
            inexOut = 1'b1;
            dotOut  = {resNeg, `FMV_INF_MAG};
        end else if (resExp <= 11'sd0) begin
            unfOut  = 1'b1;
            inexOut = 1'b1;
            dotOut  = {resNeg, 31'h0000_0000};
        end else begin
            dotOut = {resNeg, resExp[7:0],
                      rnd[24] ? rnd[23:1] : rnd[22:0]};
        end
    end

endmodule

// ===== test/fmv_transform_assertions.sv
// assertion checker for the transform unit ports
`timescale 1ns/1ps
module fmv_transform_assertions (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        issueValid,
    input wire logic [15:0] instrWord,
    input wire logic        precisionSelect,
    input wire logic [3:0]  enableVoui,
    input wire logic [3:0]  flagIn,
    input wire logic        busy_q,
    input wire logic        done_q,
    input wire logic        writeEn_q,
    input wire logic        trap_q,
    input wire logic        undefOp_q,
    input wire logic [3:0]  vecBase_q,
    input wire logic [3:0]  cause_q,
    input wire logic [3:0]  flag_q
);
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (rst);
    logic opHit;
    logic opTake;
    assign opHit = (instrWord & 16'hF3FF) == 16'hF1FD;
    assign opTake = issueValid && !busy_q && opHit && !precisionSelect;
    sequence sRun;
        busy_q [*4] ##1 (done_q && !busy_q);
    endsequence
    run_length_a: assert property (opTake |=> sRun)
        else $error("transform length wrong");
    done_pulse_a: assert property (done_q |=> !done_q)
        else $error("done not a single pulse");
    side_pulse_a: assert property (writeEn_q || trap_q |-> done_q)
        else $error("write or trap without done");
    trap_choice_a: assert property (done_q |->
        trap_q == (|$past(enableVoui, 5)) && writeEn_q == !trap_q)
        else $error("trap or write choice wrong");
    undef_pulse_a: assert property (issueValid && !busy_q
        && opHit && precisionSelect |=> undefOp_q && !busy_q)
        else $error("undefined issue not flagged");
    ignore_bad_a: assert property (issueValid && !busy_q
        && !opHit |=> !busy_q && !undefOp_q)
        else $error("foreign opcode not ignored");
    vec_base_a: assert property (opTake |=>
        vecBase_q == {$past(instrWord[11:10]), 2'b00})
        else $error("vector base wrong");
    cause_clear_a: assert property (opTake |=> cause_q == 4'h0)
        else $error("cause not cleared");
    flag_merge_a: assert property (done_q |->
        flag_q == ($past(flagIn, 5) | cause_q))
        else $error("flag merge wrong");
    busy_hold_a: assert property (busy_q |=> $stable(vecBase_q))
        else $error("issue taken while busy");
endmodule

bind fmv_transform fmv_transform_assertions u_chk (
    .mclk(mclk), .rst(rst), .issueValid(issueValid),
    .instrWord(instrWord), .precisionSelect(precisionSelect),
    .enableVoui(enableVoui), .flagIn(flagIn), .busy_q(busy_q),
    .done_q(done_q), .writeEn_q(writeEn_q), .trap_q(trap_q),
    .undefOp_q(undefOp_q), .vecBase_q(vecBase_q), .cause_q(cause_q),
    .flag_q(flag_q)
);

// ===== test/fmv_regfile_model.sv
// register file model feeding the transform unit
`timescale 1ns/1ps
module fmv_regfile_model (
    input  wire logic         mclk,
    input  wire logic         loadEn,
    input  wire logic [4:0]   loadSel,
    input  wire logic [31:0]  loadData,
    input  wire logic         wrEn,
    input  wire logic [3:0]   wrBase,
    input  wire logic [127:0] wrData,
    output logic      [511:0] backBankRegs = '0,
    output logic      [511:0] frontBankRegs = '0
);
    // bit 4 of the select picks the back bank
    always @(posedge mclk) begin
        if (loadEn && loadSel[4])
            backBankRegs[loadSel[3:0]*32 +: 32] <= loadData;
        if (loadEn && !loadSel[4])
            frontBankRegs[loadSel[3:0]*32 +: 32] <= loadData;
        // trapped results never arrive here
        if (wrEn)
            frontBankRegs[wrBase*32 +: 128] <= wrData;
    end
endmodule

// ===== test/fp_matrix_vector_transform_bench.sv
// self-checking bench of the transform unit
`timescale 1ns/1ps
`include "fmv_map.svh"
module fp_matrix_vector_transform_bench;
    logic         mclk = 1'b0;
    logic         rst, issueValid, precisionSelect, loadEn;
    logic [15:0]  instrWord;
    logic [3:0]   enableVoui, flagIn, vecBase_q, cause_q, flag_q;
    logic [4:0]   loadSel;
    logic [31:0]  loadData;
    logic [127:0] result_q;
    logic [511:0] backBankRegs, frontBankRegs;
    logic         busy_q, done_q, writeEn_q, trap_q, undefOp_q;
    logic [31:0]  bk [16];
    logic [31:0]  fr [16];
    int           err_count = 0;
    int           checks_done = 0;
    int unsigned  seed = 40605;
    always #4 mclk = ~mclk;

    fmv_transform u_dut (
        .mclk(mclk), .rst(rst), .issueValid(issueValid),
        .instrWord(instrWord), .precisionSelect(precisionSelect),
        .enableVoui(enableVoui), .flagIn(flagIn),
        .backBankRegs(backBankRegs), .frontBankRegs(frontBankRegs),
        .busy_q(busy_q), .done_q(done_q), .writeEn_q(writeEn_q),
        .trap_q(trap_q), .undefOp_q(undefOp_q), .vecBase_q(vecBase_q),
        .result_q(result_q), .cause_q(cause_q), .flag_q(flag_q)
    );
    fmv_regfile_model u_rf (
        .mclk(mclk), .loadEn(loadEn), .loadSel(loadSel),
        .loadData(loadData), .wrEn(writeEn_q), .wrBase(vecBase_q),
        .wrData(result_q), .backBankRegs(backBankRegs),
        .frontBankRegs(frontBankRegs)
    );

    // ****************************************************************
    // reference model
    // ****************************************************************
    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] val();
        int k;
        k = int'(rnd() % 17) - 8;
        return $shortrealtobits(shortreal'(k));
    endfunction
    function automatic logic isNan(input logic [31:0] w);
        return w[30:23] == 8'hFF && w[22:0] != 0;
    endfunction
    function automatic logic isInf(input logic [31:0] w);
        return w[30:0] == `FMV_INF_MAG;
    endfunction
    // element i: cause in the top four bits, word below
    function automatic logic [35:0] dot(input int i, input int b);
        logic [31:0] x, y;
        logic sn, qn, zi, ip, in;
        real s;
        {sn, qn, zi, ip, in} = 5'h00;
        s = 0.0;
        for (int j = 0; j < 4; j++) begin
            x = bk[i + 4 * j];
            y = fr[b + j];
            sn |= isNan(x) & ~x[22] | isNan(y) & ~y[22];
            qn |= isNan(x) | isNan(y);
            zi |= x[30:23] == 0 && isInf(y) || y[30:23] == 0 && isInf(x);
            if (isInf(x) | isInf(y)) begin
                if (x[31] ^ y[31]) in = 1'b1;
                else ip = 1'b1;
            end else
                s += $bitstoshortreal(x) * $bitstoshortreal(y);
        end
        if (sn | zi | ip & in & ~qn) return {4'h8, `FMV_QNAN};
        if (qn) return {4'h0, `FMV_QNAN};
        if (ip | in) return {4'h0, in, `FMV_INF_MAG};
        if (s == 0.0) return 36'h0;
        return {4'h0, $shortrealtobits(shortreal'(s))};
    endfunction

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [127:0] e,
                       input logic [127:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic put(input logic [4:0] s, input logic [31:0] d);
        loadEn = 1'b1;
        loadSel = s;
        loadData = d;
        @(negedge mclk);
        if (s[4]) bk[s[3:0]] = d;
        else fr[s[3:0]] = d;
    endtask
    task automatic run(input logic [1:0] n, input logic [3:0] en,
                       input logic [3:0] fl);
        logic [127:0] ev;
        logic [35:0] r;
        logic [3:0] ec;
        int k;
        ec = 4'h0;
        for (int i = 0; i < 4; i++) begin
            r = dot(i, 4 * n);
            ev[32 * i +: 32] = r[31:0];
            ec |= r[35:32];
        end
        loadEn = 1'b0;
        issueValid = 1'b1;
        instrWord = {4'hF, n, 10'h1FD};
        enableVoui = en;
        flagIn = fl;
        @(negedge mclk);
        // offer another vector while busy: must be ignored
        instrWord = {4'hF, ~n, 10'h1FD};
        @(negedge mclk);
        issueValid = 1'b0;
        k = 2;
        while (done_q !== 1'b1 && k < 20) begin
            @(negedge mclk);
            k++;
        end
        chk("cycles", 5, k);
        chk("result", ev, result_q);
        chk("cause", ec, cause_q);
        chk("flag", ec | fl, flag_q);
        chk("write", en == 4'h0, writeEn_q);
        chk("trap", en != 4'h0, trap_q);
        chk("base", {n, 2'b00}, vecBase_q);
        if (en == 4'h0)
            for (int i = 0; i < 4; i++) fr[4 * n + i] = ev[32 * i +: 32];
    endtask
    task automatic settle();
        @(negedge mclk);
        for (int i = 0; i < 16; i++)
            chk("front", fr[i], frontBankRegs[32 * i +: 32]);
    endtask
    task automatic poke(input logic [15:0] w, input logic p,
                        input logic eu);
        issueValid = 1'b1;
        instrWord = w;
        precisionSelect = p;
        @(negedge mclk);
        chk("undef", eu, undefOp_q);
        chk("busy", 0, busy_q);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ****************************************************************
    // sequence
    // ****************************************************************
    initial begin
        #50000;
        err_count++;
        results();
    end
    initial begin
        logic [1:0] n;
        logic [31:0] sa [5];
        logic [31:0] sb [5];
        sa = '{32'h7F800001, 32'h7F800000, 32'h7FC00000, 32'h7F800000,
               32'h3F800000};
        sb = '{32'h3F800000, 32'h3F800000, 32'h3F800000, 32'hFF800000,
               32'hFF800000};
        {rst, issueValid, precisionSelect, loadEn} = 4'h8;
        {instrWord, enableVoui, flagIn, loadSel, loadData} = '0;
        repeat (6) @(negedge mclk);
        chk("reset", 0, {busy_q, done_q, writeEn_q, trap_q, undefOp_q,
            vecBase_q, cause_q, flag_q});
        chk("reset", 0, result_q);
        rst = 1'b0;
        for (int i = 0; i < 16; i++) put({1'b1, 4'(i)}, val());
        for (int t = 0; t < 6; t++) begin
            for (int i = 0; i < 16; i++) put({1'b0, 4'(i)}, val());
            n = 2'(rnd());
            run(n, (rnd() % 3 == 0) ? 4'(rnd()) : 4'h0, 4'(rnd()));
            run(n ^ 2'd1, 4'h0, 4'h0);
            settle();
        end
        $display("random transforms done");
        for (int i = 0; i < 16; i++)
            put({1'b1, 4'(i)}, i == 0 ? 32'h0 : 32'h3F800000);
        for (int c = 0; c < 7; c++) begin
            put(5'h00, sa[c % 5]);
            put(5'h01, sb[c % 5]);
            put(5'h02, 32'h3F800000);
            put(5'h03, 32'h3F800000);
            run(2'd0, c < 5 ? 4'h0 : 4'(c * 4 - 16), 4'h3);
            settle();
        end
        $display("special operands done");
        poke(16'hF9FD, 1'b1, 1'b1);
        poke(16'hF1FC, 1'b0, 1'b0);
        poke(16'hF0FD, 1'b1, 1'b0);
        {issueValid, precisionSelect} = 2'b00;
        $display("undefined issues done");
        results();
    end
endmodule
